//--- shared/rrc_pkg.sv
// shared constants, register map and crc step for the reassembly checker
package rrc_pkg;

    // ========================================================================
    // context geometry
    localparam int SLOT_W  = 3;                    // frag_slot_id 0..7
    localparam int TERM_W  = 2;                    // source terminals 0..3
    localparam int CTX_W   = SLOT_W + TERM_W;
    localparam int CTX_N   = 1 << CTX_W;
    localparam int SLOT_N  = 1 << SLOT_W;
    localparam int LEN_W   = 12;                   // total and fragment lengths

    // ========================================================================
    // check trailers
    localparam logic [31:0]      CRC_POLY      = 32'h04C11DB7;
    localparam logic [31:0]      CRC_INIT      = 32'hFFFFFFFF;
    localparam logic [LEN_W-1:0] SEQ_TRL_BYTES = 12'h001;
    localparam logic [LEN_W-1:0] CRC_TRL_BYTES = 12'h004;
    localparam logic [LEN_W-1:0] TOTLEN_BYTES  = 12'h002;
    localparam logic [7:0]       SEQ_RESET     = 8'h00;
    localparam logic [7:0]       SEQ_STEP      = 8'h01;
    localparam logic [1:0]       CRC_LAST_IDX  = 2'h3;

    // ========================================================================
    // discard causes, one bit each on the event vector
    localparam int CAUSE_N      = 5;
    localparam int CS_SEQ       = 0;
    localparam int CS_CRC       = 1;
    localparam int CS_LOST_ST   = 2;
    localparam int CS_LOST_END  = 3;
    localparam int CS_LEN       = 4;

    // ========================================================================
    // wishbone register map
    localparam logic [7:0] REG_CTRL     = 8'h00;   // bit0: sender crc mode
    localparam logic [7:0] REG_DLV_CNT  = 8'h04;   // packets delivered
    localparam logic [7:0] REG_DROP_CNT = 8'h08;   // discard events
    localparam logic [7:0] REG_EXP_SEQ  = 8'h0C;   // expected seq of context 0
    localparam int         CTRL_CRC_BIT = 0;

    // sender trailer state
    typedef enum logic {
        RRC_TX_PASS = 1'b0,
        RRC_TX_TRL  = 1'b1
    } rrc_tx_e;

    // one byte into the crc, low bit of the byte first
    function automatic logic [31:0] rrc_crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? CRC_POLY : 32'h00000000);
        end
        return r;
    endfunction

endpackage

//--- src/rrc_top.sv
// reassembly error checker with sender trailer insertion and wishbone registers
`timescale 1ns/1ps
`default_nettype none

module rrc_top
    import rrc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    // wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // received fragment bytes
    input  wire logic              rx_valid_i,
    input  wire logic [7:0]        rx_data_i,
    input  wire logic              rx_first_i,
    input  wire logic              rx_last_i,
    input  wire logic              rx_start_i,
    input  wire logic              rx_end_i,
    input  wire logic              rx_crc_i,
    input  wire logic [SLOT_W-1:0] rx_slot_i,
    input  wire logic [TERM_W-1:0] rx_term_i,
    input  wire logic [LEN_W-1:0]  rx_len_i,
    // reassembled bytes and verdicts toward the decapsulator
    output logic                   out_valid_o,
    output logic      [7:0]        out_data_o,
    output logic      [CTX_W-1:0]  out_ctx_o,
    output logic                   dlv_o,
    output logic      [CTX_W-1:0]  dlv_ctx_o,
    output logic      [CAUSE_N-1:0] drop_o,
    output logic      [CTX_W-1:0]  drop_ctx_o,
    // sender side: higher-layer data of each fragment
    input  wire logic              tx_valid_i,
    input  wire logic [7:0]        tx_data_i,
    input  wire logic              tx_first_i,
    input  wire logic              tx_last_i,
    input  wire logic [SLOT_W-1:0] tx_slot_i,
    output logic                   tx_ready_o,
    output logic                   tx_valid_o,
    output logic      [7:0]        tx_data_o,
    output logic                   tx_last_o
);

    // ========================================================================
    // register bus
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        ctrl_crc_q;
    logic [31:0] dlv_cnt_q;
    logic [31:0] drop_cnt_q;
    logic        bus_req;
    logic        dlv_d;
    logic [CAUSE_N-1:0] drop_d;

    logic [7:0]       exp_q   [CTX_N];
    logic             act_q   [CTX_N];
    logic             mode_q  [CTX_N];
    logic [LEN_W-1:0] blen_q  [CTX_N];
    logic [LEN_W-1:0] total_q [CTX_N];
    logic [31:0]      crc_q   [CTX_N];

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;

    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            unique case (wb_adr_i)
                REG_CTRL:     rdat_q <= {31'h00000000, ctrl_crc_q};
                REG_DLV_CNT:  rdat_q <= dlv_cnt_q;
                REG_DROP_CNT: rdat_q <= drop_cnt_q;
                REG_EXP_SEQ:  rdat_q <= {24'h000000, exp_q[0]};
                default:      rdat_q <= 32'h00000000;
            endcase
        end
    end

    // control bit written through byte lane 0
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_crc_q <= 1'b0;
        end else if (bus_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            ctrl_crc_q <= wb_dat_i[CTRL_CRC_BIT];
        end
    end

    // delivery and drop counters
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dlv_cnt_q  <= 32'h00000000;
            drop_cnt_q <= 32'h00000000;
        end else begin
            dlv_cnt_q  <= dlv_cnt_q + {31'h00000000, dlv_d};
            drop_cnt_q <= drop_cnt_q + {31'h00000000, |drop_d};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ========================================================================
    // receiver: per-fragment working state
    logic             f_start_q, f_end_q, f_orphan_q, f_mode_q;
    logic [CTX_W-1:0] f_ctx_q;
    logic [LEN_W-1:0] f_len_q, f_idx_q, f_blen_q, f_total_q;
    logic [31:0]      f_crc_q, f_trl_q;

    logic             first, last, lost_end;
    logic             s_start, s_end, s_orphan, s_mode;
    logic [CTX_W-1:0] s_ctx;
    logic [LEN_W-1:0] s_len, s_idx, s_blen, s_total, tlen;
    logic [31:0]      s_crc;
    logic [31:0]      s_trl;
    logic             is_tot, is_trl, is_dat;
    logic [LEN_W-1:0] n_blen, n_total;
    logic [31:0]      n_crc, n_trl;
    logic [7:0]       e_base, e_new;
    logic             a_new;

    assign first = rx_valid_i & rx_first_i;
    assign last  = rx_valid_i & rx_last_i;

    // pick context values on a first byte, working copy otherwise
    always_comb begin
        if (first) begin
            s_ctx    = {rx_term_i, rx_slot_i};
            s_start  = rx_start_i;
            s_end    = rx_end_i;
            s_len    = rx_len_i;
            s_idx    = '0;
            s_orphan = ~rx_start_i & ~act_q[{rx_term_i, rx_slot_i}];
            s_mode   = rx_start_i ? rx_crc_i : mode_q[{rx_term_i, rx_slot_i}];
            s_blen   = rx_start_i ? '0 : blen_q[{rx_term_i, rx_slot_i}];
            s_total  = total_q[{rx_term_i, rx_slot_i}];
            s_crc    = rx_start_i ? CRC_INIT : crc_q[{rx_term_i, rx_slot_i}];
            s_trl    = 32'h00000000;
        end else begin
            s_ctx    = f_ctx_q;
            s_start  = f_start_q;
            s_end    = f_end_q;
            s_len    = f_len_q;
            s_idx    = f_idx_q;
            s_orphan = f_orphan_q;
            s_mode   = f_mode_q;
            s_blen   = f_blen_q;
            s_total  = f_total_q;
            s_crc    = f_crc_q;
            s_trl    = f_trl_q;
        end
    end

    // classify the byte and advance length, total and crc
    always_comb begin
        tlen    = s_mode ? CRC_TRL_BYTES : SEQ_TRL_BYTES;
        is_tot  = s_start && (s_idx < TOTLEN_BYTES);
        is_trl  = s_end && !is_tot && (s_idx + tlen >= s_len);
        is_dat  = !is_tot && !is_trl;
        n_total = s_total;
        if (is_tot && s_idx == '0) begin
            n_total = {rx_data_i[3:0], s_total[7:0]};
        end else if (is_tot) begin
            n_total = {s_total[LEN_W-1:8], rx_data_i};
        end
        n_blen = s_blen + {{(LEN_W-1){1'b0}}, is_dat};
        n_crc  = is_dat ? rrc_crc_byte(s_crc, rx_data_i) : s_crc;
        n_trl  = is_trl ? {s_trl[23:0], rx_data_i} : s_trl;
    end

    // START on a slot still reassembling: the older packet lost its END
    assign lost_end = first && rx_start_i && act_q[s_ctx];
    assign e_base   = (lost_end && !mode_q[s_ctx]) ? exp_q[s_ctx] + SEQ_STEP : exp_q[s_ctx];

    // verdict on the last byte of a fragment, lost END drop on the first byte of a START
    always_comb begin
        e_new  = e_base;
        a_new  = act_q[s_ctx];
        dlv_d  = 1'b0;
        drop_d = '0;
        drop_d[CS_LOST_END] = lost_end;
        if (last) begin
            if (s_orphan) begin
                drop_d[CS_LOST_ST] = 1'b1;
                if (s_end && !s_mode) begin
                    e_new = n_trl[7:0] + SEQ_STEP;
                end
            end else if (n_blen > n_total) begin
                drop_d[CS_LEN] = 1'b1;
                a_new = 1'b0;
                if (s_end && !s_start && !s_mode) begin
                    e_new = n_trl[7:0] + SEQ_STEP;
                end
            end else if (s_end) begin
                a_new = 1'b0;
                if (n_blen != n_total) begin
                    drop_d[CS_LEN] = 1'b1;
                    if (!s_mode) begin
                        e_new = n_trl[7:0] + SEQ_STEP;
                    end
                end else if (!s_mode) begin
                    e_new = n_trl[7:0] + SEQ_STEP;
                    dlv_d = (n_trl[7:0] == e_base);
                    drop_d[CS_SEQ] = (n_trl[7:0] != e_base);
                end else begin
                    dlv_d = (~n_crc == n_trl);
                    drop_d[CS_CRC] = (~n_crc != n_trl);
                end
            end else begin
                a_new = 1'b1;
            end
        end
    end

    // working copy follows each accepted byte
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            f_ctx_q    <= '0;
            f_start_q  <= 1'b0;
            f_end_q    <= 1'b0;
            f_len_q    <= '0;
            f_idx_q    <= '0;
            f_orphan_q <= 1'b1;
            f_mode_q   <= 1'b0;
            f_blen_q   <= '0;
            f_total_q  <= '0;
            f_crc_q    <= CRC_INIT;
            f_trl_q    <= 32'h00000000;
        end else if (rx_valid_i) begin
            f_ctx_q    <= s_ctx;
            f_start_q  <= s_start;
            f_end_q    <= s_end;
            f_len_q    <= s_len;
            f_idx_q    <= s_idx + {{(LEN_W-1){1'b0}}, 1'b1};
            f_orphan_q <= s_orphan;
            f_mode_q   <= s_mode;
            f_blen_q   <= n_blen;
            f_total_q  <= n_total;
            f_crc_q    <= n_crc;
            f_trl_q    <= n_trl;
        end
    end

    // context table, written back when a fragment closes, exp_q also on a lost END
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < CTX_N; i++) begin
                exp_q[i]   <= SEQ_RESET;
                act_q[i]   <= 1'b0;
                mode_q[i]  <= 1'b0;
                blen_q[i]  <= '0;
                total_q[i] <= '0;
                crc_q[i]   <= CRC_INIT;
            end
        end else begin
            if (lost_end || last) begin
                exp_q[s_ctx] <= e_new;
            end
            if (last) begin
                act_q[s_ctx] <= a_new;
                if (!s_orphan) begin
                    mode_q[s_ctx]  <= s_mode;
                    blen_q[s_ctx]  <= n_blen;
                    total_q[s_ctx] <= n_total;
                    crc_q[s_ctx]   <= n_crc;
                end
            end
        end
    end

    // output stream and event pulses
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= 8'h00;
            out_ctx_o   <= '0;
            dlv_o       <= 1'b0;
            dlv_ctx_o   <= '0;
            drop_o      <= '0;
            drop_ctx_o  <= '0;
        end else begin
            out_valid_o <= rx_valid_i && !s_orphan && is_dat;
            out_data_o  <= rx_data_i;
            out_ctx_o   <= s_ctx;
            dlv_o       <= dlv_d;
            dlv_ctx_o   <= s_ctx;
            drop_o      <= drop_d;
            drop_ctx_o  <= s_ctx;
        end
    end

    // ========================================================================
    // sender: trailer insertion per slot
    rrc_tx_e     tx_st_q;
    logic [7:0]  tx_seq_q [SLOT_N];
    logic [31:0] tx_crc_q [SLOT_N];
    logic [31:0] tx_trl_q;
    logic [1:0]  tx_cnt_q;
    logic        tx_take;
    logic [31:0] tx_crc_n;

    assign tx_take  = tx_valid_i && tx_ready_o;
    assign tx_crc_n = rrc_crc_byte(tx_first_i ? CRC_INIT : tx_crc_q[tx_slot_i], tx_data_i);

    // per-slot counters and running crc
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < SLOT_N; i++) begin
                tx_seq_q[i] <= SEQ_RESET;
                tx_crc_q[i] <= CRC_INIT;
            end
        end else if (tx_take) begin
            tx_crc_q[tx_slot_i] <= tx_crc_n;
            if (tx_last_i && !ctrl_crc_q) begin
                tx_seq_q[tx_slot_i] <= tx_seq_q[tx_slot_i] + SEQ_STEP;
            end
        end
    end

    // pass data, then emit trailer bytes high byte first
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_st_q    <= RRC_TX_PASS;
            tx_ready_o <= 1'b1;
            tx_valid_o <= 1'b0;
            tx_data_o  <= 8'h00;
            tx_last_o  <= 1'b0;
            tx_trl_q   <= 32'h00000000;
            tx_cnt_q   <= 2'h0;
        end else begin
            unique case (tx_st_q)
                RRC_TX_PASS: begin
                    tx_valid_o <= tx_take;
                    tx_data_o  <= tx_data_i;
                    tx_last_o  <= 1'b0;
                    if (tx_take && tx_last_i) begin
                        tx_st_q    <= RRC_TX_TRL;
                        tx_ready_o <= 1'b0;
                        if (ctrl_crc_q) begin
                            tx_trl_q <= ~tx_crc_n;
                            tx_cnt_q <= CRC_LAST_IDX;
                        end else begin
                            tx_trl_q <= {tx_seq_q[tx_slot_i], 24'h000000};
                            tx_cnt_q <= 2'h0;
                        end
                    end
                end
                RRC_TX_TRL: begin
                    tx_valid_o <= 1'b1;
                    tx_data_o  <= tx_trl_q[31:24];
                    tx_trl_q   <= {tx_trl_q[23:0], 8'h00};
                    tx_last_o  <= (tx_cnt_q == 2'h0);
                    tx_cnt_q   <= tx_cnt_q - 2'h1;
                    if (tx_cnt_q == 2'h0) begin
                        tx_st_q    <= RRC_TX_PASS;
                        tx_ready_o <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule // rrc_top

`default_nettype wire

//--- tb/rrc_sva.sv
// concurrent checks on the reassembly checker ports
`timescale 1ns/1ps
`default_nettype none
module rrc_sva
    import rrc_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               srst_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    input wire logic               rx_valid_i,
    input wire logic               rx_first_i,
    input wire logic               rx_last_i,
    input wire logic               out_valid_o,
    input wire logic               dlv_o,
    input wire logic [CAUSE_N-1:0] drop_o,
    input wire logic               tx_valid_i,
    input wire logic [7:0]         tx_data_i,
    input wire logic               tx_last_i,
    input wire logic               tx_ready_o,
    input wire logic               tx_valid_o,
    input wire logic [7:0]         tx_data_o,
    input wire logic               tx_last_o
);
    // ========================================================================
    // one clock domain, reset disables all
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_dlv_at_end: assert property (dlv_o |-> $past(rx_valid_i && rx_last_i))
        else $error("delivery not after last byte");
    a_drop_cause: assert property ((|drop_o) |-> $past(rx_valid_i && (rx_first_i || rx_last_i)))
        else $error("drop without fragment edge");
    a_dlv_no_bad: assert property (dlv_o |-> !drop_o[CS_SEQ] && !drop_o[CS_CRC])
        else $error("delivery with mismatch");
    a_fwd_cause: assert property (out_valid_o |-> $past(rx_valid_i)) else $error("byte out of nothing");
    a_trl_gap: assert property ((tx_valid_i && tx_ready_o && tx_last_i) |=> !tx_ready_o)
        else $error("no trailer slot");
    a_trl_bound: assert property (!tx_ready_o |-> ##[1:4] tx_ready_o) else $error("trailer too long");
    a_tx_pass: assert property ((tx_valid_i && tx_ready_o) |=> tx_valid_o && tx_data_o == $past(tx_data_i))
        else $error("sender byte lost");
    a_last_ready: assert property (tx_last_o |-> tx_valid_o && tx_ready_o) else $error("bad final byte");
endmodule // rrc_sva
bind rrc_top rrc_sva u_sva (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_first_i(rx_first_i), .rx_last_i(rx_last_i),
    .out_valid_o(out_valid_o), .dlv_o(dlv_o), .drop_o(drop_o), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
    .tx_last_i(tx_last_i), .tx_ready_o(tx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_last_o(tx_last_o));
`default_nettype wire

//--- tb/rrc_peer.sv
// decapsulator model: gathers forwarded bytes per context
`timescale 1ns/1ps
`default_nettype none
module rrc_peer
    import rrc_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               out_valid_i,
    input  wire logic [CTX_W-1:0]   out_ctx_i,
    input  wire logic               dlv_i,
    input  wire logic [CTX_W-1:0]   dlv_ctx_i,
    input  wire logic [CAUSE_N-1:0] drop_i,
    input  wire logic [CTX_W-1:0]   drop_ctx_i,
    output var  int                 pk_len_o
);
    int acc [CTX_N];
    // count per context, hand up on delivery, flush on drop
    always @(posedge clk_i) begin
        if (out_valid_i)
            acc[out_ctx_i] = acc[out_ctx_i] + 1;
        if (dlv_i) begin
            pk_len_o = acc[dlv_ctx_i];
            acc[dlv_ctx_i] = 0;
        end
        if (|drop_i)
            acc[drop_ctx_i] = 0;
    end
endmodule // rrc_peer
`default_nettype wire

//--- tb/rrc_top_bench.sv
// bench: reassembly verdicts, sender trailers, registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module rrc_top_bench
    import rrc_pkg::*;
;
    logic clk_i = 1'b0, srst_i = 1'b1, cyc = 1'b0, we = 1'b0, rxv = 1'b0, rxf = 1'b0, rxl = 1'b0;
    logic rxs = 1'b0, rxe = 1'b0, rxc = 1'b0, txv = 1'b0, txf = 1'b0, txl = 1'b0, dlv, ack, ov, txr, txvo, txlo;
    logic [7:0]  adr = 8'h00, rxd = 8'h00, txd = 8'h00, od, txdo;
    logic [31:0] wdat = 32'h00000000, rdat, rd, rng = 32'h00005626;
    logic [4:0]  rctx = 5'h00, octx, dctx, drop, drctx;
    logic [11:0] rlen = 12'h000;
    logic [5:0]  ev = 6'h00;
    logic [7:0]  fb[$], dq[$], txq[$], oq[$];
    int n_mismatch = 0, cmp_count = 0, pk_len, a, b, tl;
    rrc_top uut (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_valid_i(rxv), .rx_data_i(rxd),
        .rx_first_i(rxf), .rx_last_i(rxl), .rx_start_i(rxs), .rx_end_i(rxe), .rx_crc_i(rxc),
        .rx_slot_i(rctx[2:0]), .rx_term_i(rctx[4:3]), .rx_len_i(rlen), .out_valid_o(ov), .out_data_o(od),
        .out_ctx_o(octx), .dlv_o(dlv), .dlv_ctx_o(dctx), .drop_o(drop), .drop_ctx_o(drctx), .tx_valid_i(txv),
        .tx_data_i(txd), .tx_first_i(txf), .tx_last_i(txl), .tx_slot_i(rctx[2:0]), .tx_ready_o(txr),
        .tx_valid_o(txvo), .tx_data_o(txdo), .tx_last_o(txlo));
    rrc_peer peer (.clk_i(clk_i), .out_valid_i(ov), .out_ctx_i(octx), .dlv_i(dlv), .dlv_ctx_i(dctx),
        .drop_i(drop), .drop_ctx_i(drctx), .pk_len_o(pk_len));
    // ========================================================================
    // clock, verdict and sender output monitors
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (dlv || (|drop))
            ev <= ev | {dlv, drop};
        if (txvo)
            txq.push_back(txdo);
        if (txvo && txlo)
            tl = txq.size();
        if (ov)
            oq.push_back(od);
    end
    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction
    // reference crc, bytes in order, low bit first, inverted
    function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        foreach (q[i])
            for (int k = 0; k < 8; k++)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ q[i][k]) ? 32'h04C11DB7 : 32'h00000000);
        return ~c;
    endfunction
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    // one fragment of fb, flags set with its first byte
    task automatic frag(input logic s, input logic e, input logic c, input logic [4:0] x);
        ev = 6'h00;
        rxs <= s;
        rxe <= e;
        rxc <= c;
        rctx <= x;
        rlen <= 12'(fb.size());
        foreach (fb[i]) begin
            rxv <= 1'b1;
            rxd <= fb[i];
            rxf <= (i == 0);
            rxl <= (i == fb.size() - 1);
            @(posedge clk_i);
        end
        rxv <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic st(input logic c, input logic [4:0] x, input int tot, input int n);
        dq = {};
        oq = {};
        fb = {8'(tot >> 8), 8'(tot)};
        repeat (n) dq.push_back(rnd());
        fb = {fb, dq};
        frag(1'b1, 1'b0, c, x);
    endtask
    // e low: middle fragment; crc trailer is the reference crc xor tr
    task automatic fr(input logic c, input logic [4:0] x, input int n, input logic [31:0] tr, input logic e);
        fb = {};
        repeat (n) fb.push_back(rnd());
        dq = {dq, fb};
        if (c)
            tr = crc_of(dq) ^ tr;
        if (e && c)
            fb = {fb, tr[31:24], tr[23:16], tr[15:8], tr[7:0]};
        else if (e)
            fb = {fb, tr[7:0]};
        frag(1'b0, e, c, x);
    endtask
    task automatic vf(input logic [5:0] e, input logic [7:0] s);
        logic [31:0] r;
        `CHK("event", e, ev)
        wb(1'b0, REG_EXP_SEQ, 32'h0, r);
        `CHK("exp_seq", {24'h0, s}, r)
    endtask
    // sender packet of n random bytes, trailer follows
    task automatic tp(input int n);
        txq = {};
        dq = {};
        for (int i = 0; i < n; i++) begin
            dq.push_back(rnd());
            txv <= 1'b1;
            txd <= dq[i];
            txf <= (i == 0);
            txl <= (i == n - 1);
            @(posedge clk_i);
        end
        txv <= 1'b0;
        repeat (7) @(posedge clk_i);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
    // ========================================================================
    // scenarios
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        vf(6'h00, 8'h00);
        wb(1'b0, 8'h10, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        st(0, 0, 3, 2);
        fr(0, 0, 1, 0, 1);
        vf(6'h20, 8'h01);
        `CHK("pk_len", 3, pk_len)
        st(0, 0, 2, 1);
        fr(0, 0, 1, 8'h07, 1);
        vf(6'h01, 8'h08);
        fr(0, 0, 2, 8'hFF, 1);
        vf(6'h04, 8'h00);
        st(0, 0, 2, 1);
        st(0, 0, 2, 2);
        vf(6'h08, 8'h01);
        fr(0, 0, 0, 8'h01, 1);
        vf(6'h20, 8'h02);
        st(0, 0, 3, 1);
        fr(0, 0, 1, 8'h02, 1);
        vf(6'h10, 8'h03);
        st(0, 0, 2, 1);
        fr(0, 0, 3, 0, 0);
        vf(6'h10, 8'h03);
        st(1, 0, 5, 2);
        fr(1, 0, 3, 0, 1);
        vf(6'h20, 8'h03);
        st(1, 0, 4, 2);
        fr(1, 0, 2, 1, 1);
        vf(6'h02, 8'h03);
        st(1, 0, 4, 2);
        fr(1, 0, 1, 0, 1);
        vf(6'h10, 8'h03);
        fr(1, 0, 1, 0, 1);
        vf(6'h04, 8'h03);
        st(1, 0, 3, 1);
        fr(1, 0, 3, 0, 0);
        vf(6'h10, 8'h03);
        st(1, 0, 4, 1);
        st(1, 0, 4, 1);
        vf(6'h08, 8'h03);
        fr(1, 0, 3, 0, 1);
        vf(6'h20, 8'h03);
        st(0, 0, 2, 1);
        st(0, 5'h13, 2, 1);
        fr(0, 5'h13, 1, 8'h00, 1);
        vf(6'h20, 8'h03);
        fr(0, 0, 1, 8'h03, 1);
        vf(6'h20, 8'h04);
        for (int k = 4; k < 10; k++) begin
            a = rnd() % 6 + 1;
            b = rnd() % 6;
            st(0, 0, a + b, a);
            fr(0, 0, b, 8'(k), 1);
            vf(6'h20, 8'(k + 1));
            `CHK("rnd_len", a + b, pk_len)
            `CHK("out_data", crc_of(dq), crc_of(oq))
        end
        wb(1'b0, REG_DLV_CNT, 32'h0, rd);
        `CHK("dlv_cnt", 32'h0000000C, rd)
        wb(1'b0, REG_DROP_CNT, 32'h0, rd);
        `CHK("drop_cnt", 32'h0000000A, rd)
        tp(3);
        `CHK("seq0", 8'h00, txq[3])
        `CHK("tx_last", 4, tl)
        tp(2);
        `CHK("seq1", 8'h01, txq[2])
        wb(1'b1, REG_CTRL, 32'h1, rd);
        tp(4);
        `CHK("crc", crc_of(dq), {txq[4], txq[5], txq[6], txq[7]})
        `CHK("tx_last_crc", 8, tl)
        wb(1'b1, REG_CTRL, 32'h0, rd);
        tp(1);
        `CHK("seq2", 8'h02, txq[1])
        repeat (253) tp(1);
        tp(1);
        `CHK("seq_wrap", 8'h00, txq[1])
        `CHK("tx_pass", dq[0], txq[0])
        give_verdict();
    end
endmodule // rrc_top_bench
`default_nettype wire
